//--- inc/wold_map.svh
`ifndef WOLD_MAP_SVH
`define WOLD_MAP_SVH

// ----------------------------------------------------------------
// Magic frame layout
// ----------------------------------------------------------------
`define WOLD_SYNC_BYTE      8'hFF
`define WOLD_SYNC_COUNT     3'h6
`define WOLD_MAC_BYTES      3'h6
`define WOLD_MAC_REPEATS    5'h10

// ----------------------------------------------------------------
// Custom frame window and CRC-32
// ----------------------------------------------------------------
`define WOLD_CUSTOM_WINDOW  7'h40
`define WOLD_CRC_INIT       32'hFFFFFFFF
`define WOLD_CRC_POLY_REFL  32'hEDB88320
`define WOLD_CRC_XOROUT     32'hFFFFFFFF

// ----------------------------------------------------------------
// Output select field bit positions
// ----------------------------------------------------------------
`define WOLD_OSEL_IND_BIT   0
`define WOLD_OSEL_IRQ_BIT   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WOLD_RST_FLAG       1'h0
`define WOLD_RST_WAKE_N     1'h1

`endif

//--- inc/wold_pkg.sv
package wold_pkg;

	// Magic frame search states, one-hot
	typedef enum logic [2:0] {
		WOLD_HUNT  = 3'h1,
		WOLD_MATCH = 3'h2,
		WOLD_FOUND = 3'h4
	} wold_magic_state_type;

	// Position inside the custom window
	typedef logic [6:0] wold_byte_idx_type;

endpackage

//--- core/wold_crc32.sv
`timescale 1ns/1ps
`default_nettype none
`include "wold_map.svh"

// Byte-wide reflected Ethernet CRC-32 accumulator
module wold_crc32 (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	// Control
	input  wire logic        init_in,
	input  wire logic        en_in,
	input  wire logic [7:0]  data_in,
	// Result, final inversion applied
	output logic      [31:0] crc_out
);

	// ----------------------------------------------------------------
	// Byte update
	// ----------------------------------------------------------------
	// One byte, LSB first, as the bits arrive on the wire
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int b = 0; b < 8; b++) begin
			if (r[0] ^ d[b]) begin
				r = (r >> 1) ^ `WOLD_CRC_POLY_REFL;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	logic [31:0] crc_reg;   // Running remainder
	logic [31:0] crc_next;  // Next remainder
	logic [31:0] seed;      // Start value or running value

	// Init may coincide with the first byte of a frame
	assign seed     = init_in ? `WOLD_CRC_INIT : crc_reg;
	assign crc_next = en_in ? crc_byte(seed, data_in) : seed;
	assign crc_out  = crc_reg ^ `WOLD_CRC_XOROUT;

	// Remainder register
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			crc_reg <= `WOLD_CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

endmodule

`default_nettype wire

//--- core/wold_detector.sv
`timescale 1ns/1ps
`default_nettype none
`include "wold_map.svh"

// Summary of operation
// - Wake logic idle until global enable set.
// - Magic: six FF bytes, sixteen MAC copies.
// - Valid enabled magic frame asserts wake low.
// - Magic detection visible as status.
// - Masked bytes of first 64 feed CRC.
// - CRC match with expected value wakes.
// - Four custom types, own enable bits.
// - Expected CRC held as low/high halves.
// - 64-bit byte mask in four quarters.
// - Link up/down events wake when enabled.
// - Link change cause reported as status.
// - Strap fields route wake to pins.
// - Output select picks functions per pin.
// - Wake holds until source enable cleared.
// - Wake low active, high when idle.
// - Irq pin polarity follows invert bit.
module wold_detector
	import wold_pkg::*;
#(
	parameter int NUM_TYPES = 4,
	parameter int WINDOW    = 64
) (
	// Clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    sys_rst_in,
	// Receive byte stream
	input  wire logic                    rx_frame_in,
	input  wire logic                    rx_byte_valid_in,
	input  wire logic [7:0]              rx_byte_in,
	input  wire logic                    rx_frame_error_in,
	// Link state
	input  wire logic                    link_up_in,
	// Wake control bits
	input  wire logic                    remote_wake_enable_in,
	input  wire logic                    magic_enable_in,
	input  wire logic [NUM_TYPES-1:0]    custom_enable_in,
	input  wire logic                    link_up_enable_in,
	input  wire logic                    link_down_enable_in,
	input  wire logic [1:0]              out_select_in,
	// Local MAC address
	input  wire logic [15:0]             mac_lo_in,
	input  wire logic [15:0]             mac_mi_in,
	input  wire logic [15:0]             mac_hi_in,
	// Custom frame expected CRC, 16 bits per type
	input  wire logic [NUM_TYPES*16-1:0] custom_crc_lo_in,
	input  wire logic [NUM_TYPES*16-1:0] custom_crc_hi_in,
	// Custom frame byte masks, 16 bits per type
	input  wire logic [NUM_TYPES*16-1:0] byte_mask_q0_in,
	input  wire logic [NUM_TYPES*16-1:0] byte_mask_q1_in,
	input  wire logic [NUM_TYPES*16-1:0] byte_mask_q2_in,
	input  wire logic [NUM_TYPES*16-1:0] byte_mask_q3_in,
	// Pin routing
	input  wire logic                    wake_route_indicator_sel_in,
	input  wire logic                    wake_route_irq_sel_in,
	input  wire logic                    irq_pol_invert_in,
	input  wire logic                    indicator_func_in,
	input  wire logic                    irq_func_n_in,
	// Pins
	output logic                         indicator_pin_one_out,
	output logic                         irq_pin_n_out,
	output logic                         wake_out_on_indicator_out,
	output logic                         wake_out_on_irq_pin_out,
	output logic                         wake_req_n_out,
	// Status
	output logic                         magic_seen_out,
	output logic [NUM_TYPES-1:0]         custom_seen_out,
	output logic                         link_up_seen_out,
	output logic                         link_down_seen_out
);

	// ----------------------------------------------------------------
	// Frame boundaries
	// ----------------------------------------------------------------
	logic frame_prev_reg;  // Frame level one cycle back
	logic frame_start;     // First cycle of a frame
	logic frame_end;       // First cycle after a frame
	logic rx_take;         // Byte accepted this cycle

	assign frame_start = rx_frame_in & ~frame_prev_reg;
	assign frame_end   = ~rx_frame_in & frame_prev_reg;
	assign rx_take     = rx_frame_in & rx_byte_valid_in;

	// Frame level history
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_prev_reg <= 1'h0;
		end else begin
			frame_prev_reg <= rx_frame_in;
		end
	end

	// Error seen anywhere in the frame spoils every match
	logic frame_bad_reg;   // Error latched for this frame
	logic frame_bad_next;  // Next error state

	assign frame_bad_next = frame_start ? rx_frame_error_in
	                      : (frame_bad_reg | (rx_frame_in & rx_frame_error_in));

	// Error latch
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_bad_reg <= 1'h0;
		end else begin
			frame_bad_reg <= frame_bad_next;
		end
	end

	// ----------------------------------------------------------------
	// Magic frame search
	// ----------------------------------------------------------------
	// First MAC byte on the wire is the top byte of the high part
	function automatic logic [7:0] mac_byte(input logic [2:0] idx,
	                                        input logic [47:0] mac);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			3'h0:    r = mac[47:40];
			3'h1:    r = mac[39:32];
			3'h2:    r = mac[31:24];
			3'h3:    r = mac[23:16];
			3'h4:    r = mac[15:8];
			3'h5:    r = mac[7:0];
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	wold_magic_state_type mstate_reg;   // Search state
	wold_magic_state_type mstate_next;  // Next search state
	logic [2:0]           sync_reg;     // Sync bytes seen, saturates
	logic [2:0]           sync_next;
	logic [2:0]           midx_reg;     // Byte inside MAC copy
	logic [2:0]           midx_next;
	logic [4:0]           rep_reg;      // MAC copies completed
	logic [4:0]           rep_next;
	logic [47:0]          mac_all;      // Whole local address
	logic                 is_sync;      // Byte is all ones
	logic                 mac_hit;      // Byte equals expected MAC byte
	logic                 first_hit;    // Byte equals first MAC byte
	logic                 last_mac;     // Last byte of a copy
	logic                 last_rep;     // Last copy

	assign mac_all   = {mac_hi_in, mac_mi_in, mac_lo_in};
	assign is_sync   = (rx_byte_in == `WOLD_SYNC_BYTE);
	assign mac_hit   = (rx_byte_in == mac_byte(midx_reg, mac_all));
	assign first_hit = (rx_byte_in == mac_byte(3'h0, mac_all));
	assign last_mac  = (midx_reg == `WOLD_MAC_BYTES - 3'h1);
	assign last_rep  = (rep_reg == `WOLD_MAC_REPEATS - 5'h1);

	// Search step per received byte
	always_comb begin
		mstate_next = mstate_reg;
		sync_next   = sync_reg;
		midx_next   = midx_reg;
		rep_next    = rep_reg;
		if (frame_start) begin
			// Fresh frame, fresh search
			mstate_next = WOLD_HUNT;
			sync_next   = 3'h0;
			midx_next   = 3'h0;
			rep_next    = 5'h0;
		end
		if (rx_take) begin
			case (frame_start ? WOLD_HUNT : mstate_reg)
				WOLD_HUNT: begin
					// Extra sync bytes beyond six are tolerated
					if (is_sync && (sync_next != `WOLD_SYNC_COUNT)) begin
						sync_next = sync_next + 3'h1;
					end else if (is_sync) begin
						sync_next = `WOLD_SYNC_COUNT;
					end else if ((sync_next == `WOLD_SYNC_COUNT) && first_hit) begin
						mstate_next = WOLD_MATCH;
						midx_next   = 3'h1;
						rep_next    = 5'h0;
					end else begin
						sync_next = 3'h0;
					end
				end
				WOLD_MATCH: begin
					if (!mac_hit) begin
						// Broken sequence, restart on this byte
						mstate_next = WOLD_HUNT;
						sync_next   = is_sync ? 3'h1 : 3'h0;
					end else if (last_mac && last_rep) begin
						mstate_next = WOLD_FOUND;
					end else if (last_mac) begin
						midx_next = 3'h0;
						rep_next  = rep_reg + 5'h1;
					end else begin
						midx_next = midx_reg + 3'h1;
					end
				end
				WOLD_FOUND: begin
					// Trailing bytes do not undo a find
					mstate_next = WOLD_FOUND;
				end
				default: begin
					mstate_next = WOLD_HUNT;
				end
			endcase
		end
	end

	// Search registers
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mstate_reg <= WOLD_HUNT;
			sync_reg   <= 3'h0;
			midx_reg   <= 3'h0;
			rep_reg    <= 5'h0;
		end else begin
			mstate_reg <= mstate_next;
			sync_reg   <= sync_next;
			midx_reg   <= midx_next;
			rep_reg    <= rep_next;
		end
	end

	// Judged at frame end so a damaged frame is not accepted
	logic magic_event;
	assign magic_event = frame_end & ~frame_bad_reg & (mstate_reg == WOLD_FOUND);

	// ----------------------------------------------------------------
	// Custom frame CRC
	// ----------------------------------------------------------------
	wold_byte_idx_type bidx_reg;   // Byte position in frame
	wold_byte_idx_type bidx_next;
	logic              in_window;  // Byte inside leading window

	assign in_window = (bidx_next < WINDOW[6:0]);
	assign bidx_next = frame_start ? 7'h00 : bidx_reg;

	// Position counter, saturates just past the window
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bidx_reg <= 7'h00;
		end else if (rx_take && in_window) begin
			bidx_reg <= bidx_next + 7'h01;
		end else begin
			bidx_reg <= bidx_next;
		end
	end

	logic [NUM_TYPES-1:0] custom_event;  // Match at frame end per type

	genvar t;
	generate
		for (t = 0; t < NUM_TYPES; t++) begin : g_type
			logic [63:0] mask;   // Full byte-select mask
			logic [31:0] want;   // Expected CRC
			logic [31:0] crc;    // Computed CRC
			logic        sel;    // This byte feeds the CRC

			// Quarter q0 covers bytes 0 to 15
			assign mask   = {byte_mask_q3_in[t*16 +: 16], byte_mask_q2_in[t*16 +: 16],
			                 byte_mask_q1_in[t*16 +: 16], byte_mask_q0_in[t*16 +: 16]};
			assign want   = {custom_crc_hi_in[t*16 +: 16], custom_crc_lo_in[t*16 +: 16]};
			assign sel    = rx_take & in_window & mask[bidx_next[5:0]];

			wold_crc32 u_crc (
				.clk_sys_in (clk_sys_in),
				.sys_rst_in (sys_rst_in),
				.init_in    (frame_start),
				.en_in      (sel),
				.data_in    (rx_byte_in),
				.crc_out    (crc)
			);

			// Remainder is final on the cycle after the last byte
			assign custom_event[t] = frame_end & ~frame_bad_reg & (crc == want);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Link change detection
	// ----------------------------------------------------------------
	logic link_prev_reg;   // Link level one cycle back
	logic primed_reg;      // History valid, avoids a false edge at reset
	logic link_rise;
	logic link_fall;

	assign link_rise = primed_reg & link_up_in & ~link_prev_reg;
	assign link_fall = primed_reg & ~link_up_in & link_prev_reg;

	// Link history
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			link_prev_reg <= 1'h0;
			primed_reg    <= 1'h0;
		end else begin
			link_prev_reg <= link_up_in;
			primed_reg    <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// Sticky wake sources
	// ----------------------------------------------------------------
	// Clear is by dropping the enable, which also blocks the set,
	// so a set and a clear can never meet in one cycle
	logic                 magic_reg;
	logic                 magic_next;
	logic [NUM_TYPES-1:0] custom_reg;
	logic [NUM_TYPES-1:0] custom_next;
	logic                 lup_reg;
	logic                 lup_next;
	logic                 ldn_reg;
	logic                 ldn_next;
	logic                 armed;  // Global enable

	assign armed       = remote_wake_enable_in;
	assign magic_next  = magic_enable_in & (magic_reg | (armed & magic_event));
	assign custom_next = custom_enable_in
	                   & (custom_reg | ({NUM_TYPES{armed}} & custom_event));
	assign lup_next    = link_up_enable_in & (lup_reg | (armed & link_rise));
	assign ldn_next    = link_down_enable_in & (ldn_reg | (armed & link_fall));

	// Source flags
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			magic_reg  <= `WOLD_RST_FLAG;
			custom_reg <= '0;
			lup_reg    <= `WOLD_RST_FLAG;
			ldn_reg    <= `WOLD_RST_FLAG;
		end else begin
			magic_reg  <= magic_next;
			custom_reg <= custom_next;
			lup_reg    <= lup_next;
			ldn_reg    <= ldn_next;
		end
	end

	assign magic_seen_out     = magic_reg;
	assign custom_seen_out    = custom_reg;
	assign link_up_seen_out   = lup_reg;
	assign link_down_seen_out = ldn_reg;

	// ----------------------------------------------------------------
	// Wake output and pin routing
	// ----------------------------------------------------------------
	logic wake_n_reg;   // Low while any source holds
	logic wake_n_next;
	logic ind_route;    // Indicator pin carries wake
	logic irq_route;    // Irq pin carries wake
	logic irq_wake;     // Wake level on irq pin after polarity

	assign wake_n_next = ~(magic_next | (|custom_next) | lup_next | ldn_next);

	// Registered so the pin never glitches
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wake_n_reg <= `WOLD_RST_WAKE_N;
		end else begin
			wake_n_reg <= wake_n_next;
		end
	end

	assign ind_route = wake_route_indicator_sel_in & out_select_in[`WOLD_OSEL_IND_BIT];
	assign irq_route = wake_route_irq_sel_in & out_select_in[`WOLD_OSEL_IRQ_BIT];
	assign irq_wake  = wake_n_reg ^ irq_pol_invert_in;

	assign wake_req_n_out            = wake_n_reg;
	assign wake_out_on_indicator_out = ind_route ? wake_n_reg : 1'h1;
	assign wake_out_on_irq_pin_out   = irq_route ? irq_wake : ~irq_pol_invert_in;
	assign indicator_pin_one_out     = ind_route ? wake_n_reg : indicator_func_in;
	assign irq_pin_n_out             = irq_route ? irq_wake : irq_func_n_in;

endmodule

`default_nettype wire

//--- verification/wold_detector_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port checks for the wake detector
// ----------------------------------------------------------------
module wold_detector_properties
	import wold_pkg::*;
#(
	parameter int NUM_TYPES = 4
) (
	// Clock and reset
	input wire logic                 clk_sys_in,
	input wire logic                 sys_rst_in,
	// Causes
	input wire logic                 rx_frame_in,
	input wire logic                 link_up_in,
	input wire logic                 remote_wake_enable_in,
	input wire logic                 magic_enable_in,
	input wire logic [NUM_TYPES-1:0] custom_enable_in,
	input wire logic                 link_up_enable_in,
	input wire logic                 link_down_enable_in,
	input wire logic [1:0]           out_select_in,
	input wire logic                 wake_route_indicator_sel_in,
	input wire logic                 wake_route_irq_sel_in,
	input wire logic                 irq_pol_invert_in,
	// Effects
	input wire logic                 indicator_pin_one_out,
	input wire logic                 irq_pin_n_out,
	input wire logic                 wake_req_n_out,
	input wire logic                 magic_seen_out,
	input wire logic [NUM_TYPES-1:0] custom_seen_out,
	input wire logic                 link_up_seen_out,
	input wire logic                 link_down_seen_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	// Frame flags, and any source holding the wake
	wire logic [NUM_TYPES:0] fr_flags = {magic_seen_out, custom_seen_out};
	wire logic               any_flag = (|fr_flags) | link_up_seen_out | link_down_seen_out;

	a_wake_tracks: assert property (wake_req_n_out != any_flag)
		else $error("wake level does not follow flags");
	a_magic_armed: assert property ($rose(magic_seen_out) |->
		$past(magic_enable_in) && $past(remote_wake_enable_in))
		else $error("magic flag without enables");
	a_magic_drop: assert property (!magic_enable_in |=> !magic_seen_out)
		else $error("magic flag kept after enable drop");
	a_custom_drop: assert property (1'b1 |=>
		(custom_seen_out & ~$past(custom_enable_in)) == '0)
		else $error("custom flag without its enable");
	// Frame matches settle only once the frame is over
	a_flag_at_end: assert property ((fr_flags & ~$past(fr_flags)) != '0 |->
		!$past(rx_frame_in))
		else $error("frame flag before frame end");
	a_link_rise: assert property ($rose(link_up_in) && link_up_enable_in &&
		remote_wake_enable_in |-> ##[1:3] link_up_seen_out)
		else $error("link up not flagged");
	a_link_fall: assert property ($fell(link_up_in) && link_down_enable_in &&
		remote_wake_enable_in |-> ##[1:3] link_down_seen_out)
		else $error("link down not flagged");
	a_ind_route: assert property (wake_route_indicator_sel_in && out_select_in[0] |->
		indicator_pin_one_out == wake_req_n_out)
		else $error("indicator pin not carrying wake");
	a_irq_route: assert property (wake_route_irq_sel_in && out_select_in[1] |->
		irq_pin_n_out == (wake_req_n_out ^ irq_pol_invert_in))
		else $error("irq pin wake polarity wrong");

	c_magic: cover property ($rose(magic_seen_out));
	c_custom: cover property ($rose(|custom_seen_out));
	c_link: cover property ($rose(link_down_seen_out));
endmodule

bind wold_detector wold_detector_properties #(.NUM_TYPES(NUM_TYPES)) u_props (
	.clk_sys_in, .sys_rst_in, .rx_frame_in, .link_up_in, .remote_wake_enable_in,
	.magic_enable_in, .custom_enable_in, .link_up_enable_in, .link_down_enable_in,
	.out_select_in, .wake_route_indicator_sel_in, .wake_route_irq_sel_in,
	.irq_pol_invert_in, .indicator_pin_one_out, .irq_pin_n_out, .wake_req_n_out,
	.magic_seen_out, .custom_seen_out, .link_up_seen_out, .link_down_seen_out
);

`default_nettype wire

//--- verification/wold_lp_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Remote link partner sending frames
// ----------------------------------------------------------------
module wold_lp_model
	import wold_pkg::*;
(
	// Clock
	input  wire logic  clk_sys_in,
	// Received stream
	output logic       rx_frame_in,
	output logic       rx_byte_valid_in,
	output logic [7:0] rx_byte_in,
	output logic       rx_frame_error_in
);
	// Frame image, loaded by the bench
	logic [7:0] buf_mem [0:127];

	initial begin
		{rx_frame_in, rx_byte_valid_in, rx_frame_error_in} = 3'h0;
		rx_byte_in = 8'h00;
	end

	// One frame; slow adds idle cycles between bytes
	task automatic send(input int n, input int slow, input logic bad);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_in);
			{rx_frame_in, rx_byte_valid_in} = 2'h3;
			rx_byte_in = buf_mem[i];
			rx_frame_error_in = bad && (i == 3);
			repeat (slow) begin
				@(negedge clk_sys_in);
				// Idle byte lane never shows the last byte
				{rx_byte_valid_in, rx_frame_error_in} = 2'h0;
				rx_byte_in = ~buf_mem[i];
			end
		end
		@(negedge clk_sys_in);
		{rx_frame_in, rx_byte_valid_in, rx_frame_error_in} = 3'h0;
		rx_byte_in = ~rx_byte_in;
		repeat (6) @(negedge clk_sys_in);
	endtask
endmodule

`default_nettype wire

//--- verification/wold_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wold_map.svh"

module wold_detector_tb
	import wold_pkg::*;
;
	localparam int NT = 4;
	// Stimulus
	logic            clk_sys_in = 1'b0;
	logic            sys_rst_in = 1'b1;
	logic            link_up_in, remote_wake_enable_in, magic_enable_in;
	logic            link_up_enable_in, link_down_enable_in, irq_pol_invert_in;
	logic            wake_route_indicator_sel_in, wake_route_irq_sel_in;
	logic            indicator_func_in, irq_func_n_in;
	logic            rx_frame_in, rx_byte_valid_in, rx_frame_error_in;
	logic [7:0]      rx_byte_in;
	logic [1:0]      out_select_in;
	logic [NT-1:0]   custom_enable_in, custom_seen_out;
	logic [15:0]     mac_lo_in, mac_mi_in, mac_hi_in;
	logic [NT*16-1:0] custom_crc_lo_in, custom_crc_hi_in;
	logic [NT*16-1:0] byte_mask_q0_in, byte_mask_q1_in, byte_mask_q2_in, byte_mask_q3_in;
	// Observed
	logic            indicator_pin_one_out, irq_pin_n_out, wake_req_n_out;
	logic            wake_out_on_indicator_out, wake_out_on_irq_pin_out;
	logic            magic_seen_out, link_up_seen_out, link_down_seen_out;
	int              err_total = 0;
	int              tests_run = 0;

	always #12.5 clk_sys_in = ~clk_sys_in;

	wold_detector #(.NUM_TYPES(NT), .WINDOW(64)) u_dut (
		.clk_sys_in, .sys_rst_in, .rx_frame_in, .rx_byte_valid_in, .rx_byte_in,
		.rx_frame_error_in, .link_up_in, .remote_wake_enable_in, .magic_enable_in,
		.custom_enable_in, .link_up_enable_in, .link_down_enable_in, .out_select_in,
		.mac_lo_in, .mac_mi_in, .mac_hi_in, .custom_crc_lo_in, .custom_crc_hi_in,
		.byte_mask_q0_in, .byte_mask_q1_in, .byte_mask_q2_in, .byte_mask_q3_in,
		.wake_route_indicator_sel_in, .wake_route_irq_sel_in, .irq_pol_invert_in,
		.indicator_func_in, .irq_func_n_in, .indicator_pin_one_out, .irq_pin_n_out,
		.wake_out_on_indicator_out, .wake_out_on_irq_pin_out, .wake_req_n_out,
		.magic_seen_out, .custom_seen_out, .link_up_seen_out, .link_down_seen_out
	);
	wold_lp_model u_lp (.clk_sys_in, .rx_frame_in, .rx_byte_valid_in, .rx_byte_in,
		.rx_frame_error_in);

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	// Reflected CRC-32, one byte
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {24'h000000, b};
		for (int k = 0; k < 8; k++)
			c = c[0] ? ((c >> 1) ^ `WOLD_CRC_POLY_REFL) : (c >> 1);
		return c;
	endfunction

	// Reset pulse, then idle values
	task automatic t_reset();
		sys_rst_in = 1'b1;
		tick(4);
		chk({wake_req_n_out, magic_seen_out, custom_seen_out, link_up_seen_out,
			link_down_seen_out}, 8'h80, "reset state");
		sys_rst_in = 1'b0;
		tick(2);
		chk({wake_req_n_out, custom_seen_out, link_down_seen_out}, 6'h20, "release");
	endtask

	// Magic frame: disarmed, short, errored, then good
	task automatic t_magic();
		for (int i = 0; i < 104; i++)
			u_lp.buf_mem[i] = (i < 2) ? 8'h00 : (i < 8) ? 8'hFF :
				8'({mac_hi_in, mac_mi_in, mac_lo_in} >> (8 * (5 - (i - 8) % 6)));
		magic_enable_in = 1'b1;
		u_lp.send(104, 0, 1'b0);
		chk(magic_seen_out, 1'b0, "magic disarmed");
		remote_wake_enable_in = 1'b1;
		u_lp.send(98, 0, 1'b0);
		chk(magic_seen_out, 1'b0, "fifteen copies");
		u_lp.send(104, 0, 1'b1);
		chk(magic_seen_out, 1'b0, "errored magic");
		u_lp.send(104, 1, 1'b0);
		chk({magic_seen_out, wake_req_n_out}, 2'h2, "magic wake");
		magic_enable_in = 1'b0;
		tick(3);
		chk({magic_seen_out, wake_req_n_out}, 2'h1, "magic clear");
	endtask

	// Each custom type picks bytes t, 20+t and 63
	task automatic t_custom();
		logic [31:0] c;
		for (int t = 0; t < NT; t++) begin
			for (int i = 0; i < 70; i++)
				u_lp.buf_mem[i] = 8'(i * 7 + t * 29);
			{byte_mask_q0_in, byte_mask_q1_in, byte_mask_q2_in, byte_mask_q3_in} = '0;
			byte_mask_q0_in[t*16+t] = 1'b1;
			byte_mask_q1_in[t*16+4+t] = 1'b1;
			byte_mask_q3_in[t*16+15] = 1'b1;
			c = crc_step(`WOLD_CRC_INIT, u_lp.buf_mem[t]);
			c = crc_step(c, u_lp.buf_mem[20+t]);
			c = ~crc_step(c, u_lp.buf_mem[63]);
			custom_crc_lo_in = {NT{16'h5A5A}};
			custom_crc_hi_in = {NT{16'hA5A5}};
			{custom_crc_hi_in[t*16+:16], custom_crc_lo_in[t*16+:16]} = c;
			custom_enable_in = 4'hF;
			u_lp.send(70, t % 2, 1'b0);
			chk(custom_seen_out, 64'h1 << t, "custom match");
			chk(wake_req_n_out, 1'b0, "custom wake");
			custom_enable_in[t] = 1'b0;
			tick(3);
			chk({custom_seen_out, wake_req_n_out}, 5'h01, "custom clear");
			custom_enable_in = 4'h0;
		end
	endtask

	// Link changes, each direction with its own enable
	task automatic t_link();
		link_up_enable_in = 1'b1;
		link_up_in = 1'b1;
		tick(4);
		chk({link_up_seen_out, wake_req_n_out}, 2'h2, "up wake");
		link_up_in = 1'b0;
		tick(4);
		chk(link_down_seen_out, 1'b0, "down masked");
		{link_up_enable_in, link_down_enable_in} = 2'h1;
		tick(3);
		chk(wake_req_n_out, 1'b1, "up clear");
		link_up_in = 1'b1;
		tick(4);
		chk(link_up_seen_out, 1'b0, "up masked");
		link_up_in = 1'b0;
		tick(4);
		chk({link_down_seen_out, wake_req_n_out}, 2'h2, "down wake");
	endtask

	// Every routing, select and polarity setting against wake level w
	task automatic t_route(input logic w);
		logic ri, rq, iv;
		for (int k = 0; k < 32; k++) begin
			{irq_pol_invert_in, wake_route_irq_sel_in, wake_route_indicator_sel_in,
				out_select_in} = 5'(k);
			ri = wake_route_indicator_sel_in & out_select_in[0];
			rq = wake_route_irq_sel_in & out_select_in[1];
			iv = irq_pol_invert_in;
			tick(1);
			chk(indicator_pin_one_out, ri ? w : indicator_func_in, "ind pin");
			chk(wake_out_on_indicator_out, ri ? w : 1'b1, "ind wake");
			chk(irq_pin_n_out, rq ? w ^ iv : irq_func_n_in, "irq pin");
			chk(wake_out_on_irq_pin_out, rq ? w ^ iv : !iv, "irq wake");
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{link_up_in, remote_wake_enable_in, magic_enable_in, link_up_enable_in} = 4'h0;
		{link_down_enable_in, irq_pol_invert_in, wake_route_irq_sel_in} = 3'h0;
		{wake_route_indicator_sel_in, out_select_in, custom_enable_in} = 7'h00;
		{indicator_func_in, irq_func_n_in} = 2'h2;
		{mac_hi_in, mac_mi_in, mac_lo_in} = 48'h02A45C319E07;
		{custom_crc_lo_in, custom_crc_hi_in} = '0;
		{byte_mask_q0_in, byte_mask_q1_in, byte_mask_q2_in, byte_mask_q3_in} = '0;
		t_reset();
		t_magic();
		t_custom();
		t_link();
		t_route(1'b0);
		t_reset();
		link_down_enable_in = 1'b0;
		t_route(1'b1);
		wrap_up();
	end

	// Hang guard, well past the expected run
	initial begin
		#500000;
		err_total++;
		wrap_up();
	end
endmodule

`default_nettype wire
